// ---- shared/dcp_pkg.sv ----
// package for the daughter card parallel port
package dcp_pkg;

    // ==========================================================
    // register map, wishbone byte addresses
    localparam logic [7:0] DCP_CTRL_ADDR    = 8'h00;
    localparam logic [7:0] DCP_RESET_ADDR   = 8'h04;
    localparam logic [7:0] DCP_STATUS_ADDR  = 8'h08;
    localparam logic [7:0] DCP_WAIT_ADDR    = 8'h0C;

    // ==========================================================
    // field positions
    localparam int DCP_CTRL_FLAG_BIT     = 0;
    localparam int DCP_RST_SITE_BIT      = 0;
    localparam int DCP_RST_EXT_BIT       = 1;
    localparam int DCP_STAT_BUSY_BIT     = 0;
    localparam int DCP_STAT_FLAG_BIT     = 1;
    localparam int DCP_STAT_TOUT_BIT     = 2;

    // ==========================================================
    // reset values and widths
    localparam logic [1:0] DCP_RESET_RST   = 2'h0;
    localparam logic [3:0] DCP_WAIT_RST    = 4'h1;
    localparam int         DCP_ADDR_W      = 6;
    localparam int         DCP_DATA_W      = 8;
    localparam int         DCP_CPU_DATA_W  = 16;

    // ==========================================================
    // timing: time allowed for card ready before abort
    localparam int DCP_CLK_MHZ          = 100;
    localparam int DCP_READY_TOUT_NS    = 10000;
    localparam int DCP_READY_TOUT_CYC   = DCP_READY_TOUT_NS * DCP_CLK_MHZ / 1000;

    // ==========================================================
    // request carried from host to engine
    typedef struct packed {
        logic                  write;
        logic [DCP_ADDR_W-1:0] addr;
        logic [DCP_DATA_W-1:0] wdata;
    } dcp_req_t;

    typedef enum logic [3:0] {
        DCP_IDLE  = 4'b0001,
        DCP_SETUP = 4'b0010,
        DCP_STRB  = 4'b0100,
        DCP_DONE  = 4'b1000
    } dcp_state_t;

endpackage

// ---- rtl/dcp_card_engine.sv ----
// card bus engine: strobe and write-enable cycle ended by ready or by the ready timeout
module dcp_card_engine #(
    parameter int TOUT_CYC = dcp_pkg::DCP_READY_TOUT_CYC
) (
    // clock and reset
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    // request side
    input  wire logic                            start_i,
    input  wire dcp_pkg::dcp_req_t               req_i,
    input  wire logic [3:0]                      setup_cyc_i,
    output logic                                 done_o,
    output logic                                 tout_o,
    output logic [dcp_pkg::DCP_DATA_W-1:0]       rdata_o,
    output logic                                 busy_o,
    // card pins
    output logic                                 card_transfer_strobe_n_o,
    output logic                                 card_write_enable_n_o,
    output logic [dcp_pkg::DCP_ADDR_W-1:0]       card_addr_o,
    output logic [dcp_pkg::DCP_DATA_W-1:0]       card_data_o,
    output logic                                 card_data_oe_n_o,
    input  wire logic [dcp_pkg::DCP_DATA_W-1:0]  card_data_i,
    input  wire logic                            card_ready_n_i
);

    dcp_pkg::dcp_state_t state_r;
    logic [3:0]          wait_r;
    logic [31:0]         tout_r;

    assign busy_o = (state_r != dcp_pkg::DCP_IDLE);

    // ==========================================================
    // sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r                  <= dcp_pkg::DCP_IDLE;
            wait_r                   <= 4'h0;
            tout_r                   <= 32'h0000_0000;
            done_o                   <= 1'b0;
            tout_o                   <= 1'b0;
            rdata_o                  <= 8'h00;
            card_transfer_strobe_n_o <= 1'b1;
            card_write_enable_n_o    <= 1'b1;
            card_addr_o              <= 6'h00;
            card_data_o              <= 8'h00;
            card_data_oe_n_o         <= 1'b1;
        end else begin
            done_o <= 1'b0;
            tout_o <= 1'b0;
            case (state_r)
                dcp_pkg::DCP_IDLE: begin
                    if (start_i) begin
                        card_addr_o           <= req_i.addr;
                        card_data_o           <= req_i.wdata;
                        card_write_enable_n_o <= ~req_i.write;
                        card_data_oe_n_o      <= ~req_i.write;
                        wait_r                <= setup_cyc_i;
                        state_r               <= dcp_pkg::DCP_SETUP;
                    end
                end
                dcp_pkg::DCP_SETUP: begin
                    if (wait_r == 4'h0) begin
                        card_transfer_strobe_n_o <= 1'b0;
                        tout_r                   <= 32'h0000_0000;
                        state_r                  <= dcp_pkg::DCP_STRB;
                    end else begin
                        wait_r <= wait_r - 4'h1;
                    end
                end
                dcp_pkg::DCP_STRB: begin
                    if (!card_ready_n_i) begin
                        rdata_o                  <= card_data_i;
                        card_transfer_strobe_n_o <= 1'b1;
                        done_o                   <= 1'b1;
                        state_r                  <= dcp_pkg::DCP_DONE;
                    end else if (tout_r == TOUT_CYC - 1) begin
                        card_transfer_strobe_n_o <= 1'b1;
                        done_o                   <= 1'b1;
                        tout_o                   <= 1'b1;
                        rdata_o                  <= 8'hFF;
                        state_r                  <= dcp_pkg::DCP_DONE;
                    end else begin
                        tout_r <= tout_r + 32'h0000_0001;
                    end
                end
                dcp_pkg::DCP_DONE: begin
                    card_write_enable_n_o <= 1'b1;
                    card_data_oe_n_o      <= 1'b1;
                    state_r               <= dcp_pkg::DCP_IDLE;
                end
                default: begin
                    state_r <= dcp_pkg::DCP_IDLE;
                end
            endcase
        end
    end

endmodule

// ---- rtl/dcp_port.sv ----
// wishbone slave top for the daughter card parallel port
// Operation
// - the card is reachable only by i/o accesses while the processor flag is high.
// - the card data path is eight bits on the low byte of the sixteen-bit bus.
// - each transfer uses a data strobe plus a separate write enable.
// - the host does not finish a card transfer until card ready is seen; the code also ends it after TOUT_CYC cycles without ready.
// - one software reset bit drives the shared reset of both card sites.
// - a second independent reset bit drives the extender connector reset.
// - software sets wait and clock settings so card cycles meet timing; the code has only the wait register, with no clock setting.
// - the strobe is active low and only asserted for card-area accesses.
// - the write enable is active low and asserted for writes; the code asserts it only for writes with wb_sel_i[0] set.
// - a six-bit register address comes from the lowest address lines.
module dcp_port #(
    parameter int TOUT_CYC = dcp_pkg::DCP_READY_TOUT_CYC
) (
    // clock and reset
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    // wishbone slave
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    input  wire logic                            wb_we_i,
    input  wire logic [7:0]                      wb_adr_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic [31:0]                     wb_dat_i,
    output logic [31:0]                          wb_dat_o,
    output logic                                 wb_ack_o,
    // card i/o window select
    input  wire logic                            io_space_i,
    // card pins
    output logic                                 card_transfer_strobe_n_o,
    output logic                                 card_write_enable_n_o,
    output logic [dcp_pkg::DCP_ADDR_W-1:0]       card_addr_o,
    output logic [dcp_pkg::DCP_DATA_W-1:0]       card_data_o,
    output logic                                 card_data_oe_n_o,
    input  wire logic [dcp_pkg::DCP_DATA_W-1:0]  card_data_i,
    input  wire logic                            card_ready_n_i,
    // resets
    output logic                                 site_reset_n_o,
    output logic                                 extender_reset_n_o
);

    logic              flag_r;
    logic [1:0]        reset_r;
    logic [3:0]        wait_r;
    logic              tout_seen_r;
    logic              pend_r;
    logic              start;
    logic              eng_done;
    logic              eng_tout;
    logic              eng_busy;
    logic [7:0]        eng_rdata;
    logic              req;
    logic              reg_hit;
    logic              card_hit;
    dcp_pkg::dcp_req_t card_req;

    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign reg_hit  = req && !io_space_i;
    assign card_hit = req && io_space_i && flag_r;
    assign start    = card_hit && !pend_r;

    assign card_req.write = wb_we_i && wb_sel_i[0];
    assign card_req.addr  = wb_adr_i[dcp_pkg::DCP_ADDR_W-1:0];
    assign card_req.wdata = wb_dat_i[dcp_pkg::DCP_DATA_W-1:0];

    // ==========================================================
    // card engine
    dcp_card_engine #(
        .TOUT_CYC (TOUT_CYC)
    ) i_dcp_card_engine (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .start_i                  (start),
        .req_i                    (card_req),
        .setup_cyc_i              (wait_r),
        .done_o                   (eng_done),
        .tout_o                   (eng_tout),
        .rdata_o                  (eng_rdata),
        .busy_o                   (eng_busy),
        .card_transfer_strobe_n_o (card_transfer_strobe_n_o),
        .card_write_enable_n_o    (card_write_enable_n_o),
        .card_addr_o              (card_addr_o),
        .card_data_o              (card_data_o),
        .card_data_oe_n_o         (card_data_oe_n_o),
        .card_data_i              (card_data_i),
        .card_ready_n_i           (card_ready_n_i)
    );

    // ==========================================================
    // pending card request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_r <= 1'b0;
        end else if (start) begin
            pend_r <= 1'b1;
        end else if (eng_done) begin
            pend_r <= 1'b0;
        end
    end

    // ==========================================================
    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r  <= 1'b0;
            reset_r <= dcp_pkg::DCP_RESET_RST;
            wait_r  <= dcp_pkg::DCP_WAIT_RST;
        end else if (reg_hit && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                dcp_pkg::DCP_CTRL_ADDR: begin
                    flag_r <= wb_dat_i[dcp_pkg::DCP_CTRL_FLAG_BIT];
                end
                dcp_pkg::DCP_RESET_ADDR: begin
                    reset_r <= wb_dat_i[1:0];
                end
                dcp_pkg::DCP_WAIT_ADDR: begin
                    wait_r <= wb_dat_i[3:0];
                end
                default: begin
                    flag_r <= flag_r;
                end
            endcase
        end
    end

    // ==========================================================
    // reset pins, bit high holds reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            site_reset_n_o     <= 1'b1;
            extender_reset_n_o <= 1'b1;
        end else begin
            site_reset_n_o     <= ~reset_r[dcp_pkg::DCP_RST_SITE_BIT];
            extender_reset_n_o <= ~reset_r[dcp_pkg::DCP_RST_EXT_BIT];
        end
    end

    // ==========================================================
    // sticky ready timeout, set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tout_seen_r <= 1'b0;
        end else if (eng_tout) begin
            tout_seen_r <= 1'b1;
        end else if (reg_hit && wb_we_i && wb_sel_i[0]
                     && wb_adr_i == dcp_pkg::DCP_STATUS_ADDR
                     && wb_dat_i[dcp_pkg::DCP_STAT_TOUT_BIT]) begin
            tout_seen_r <= 1'b0;
        end
    end

    // ==========================================================
    // wishbone answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            if (reg_hit) begin
                wb_ack_o <= 1'b1;
                case (wb_adr_i)
                    dcp_pkg::DCP_CTRL_ADDR:   wb_dat_o <= {31'h0000_0000, flag_r};
                    dcp_pkg::DCP_RESET_ADDR:  wb_dat_o <= {30'h0000_0000, reset_r};
                    dcp_pkg::DCP_STATUS_ADDR: begin
                        wb_dat_o <= {29'h0000_0000, tout_seen_r, flag_r, eng_busy};
                    end
                    dcp_pkg::DCP_WAIT_ADDR:   wb_dat_o <= {28'h0000_000, wait_r};
                    default:                  wb_dat_o <= 32'h0000_0000;
                endcase
            end else if (req && io_space_i && !flag_r) begin
                wb_ack_o <= 1'b1;
                wb_dat_o <= 32'h0000_00FF;
            end else if (pend_r && eng_done) begin
                wb_ack_o <= 1'b1;
                wb_dat_o <= {24'h00_0000, eng_rdata};
            end
        end
    end

endmodule

// ---- bench/dcp_port_sva.sv ----
// checker for the daughter card parallel port
module dcp_port_sva #(
    parameter int TOUT_CYC = dcp_pkg::DCP_READY_TOUT_CYC
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        io_space_i,
    // card pins and resets
    input wire logic        card_transfer_strobe_n_o,
    input wire logic        card_write_enable_n_o,
    input wire logic [5:0]  card_addr_o,
    input wire logic [7:0]  card_data_o,
    input wire logic        card_data_oe_n_o,
    input wire logic        card_ready_n_i,
    input wire logic        site_reset_n_o,
    input wire logic        extender_reset_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // helpers
    logic       rst_wr;
    logic [2:0] wr_hist_r;
    int         low_cnt_r;
    assign rst_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
        && wb_adr_i == dcp_pkg::DCP_RESET_ADDR;
    always_ff @(posedge clk_i) begin
        wr_hist_r <= rst_i ? 3'h0 : {wr_hist_r[1:0], rst_wr};
        low_cnt_r <= (rst_i || card_transfer_strobe_n_o) ? 0 : low_cnt_r + 1;
    end
    // ==========================================================
    // properties
    property p_strobe_cause; !card_transfer_strobe_n_o |-> io_space_i && wb_cyc_i && wb_stb_i; endproperty
    a_strobe_cause: assert property (p_strobe_cause) else $error("stray strobe");
    property p_hold; !card_transfer_strobe_n_o && !$past(card_transfer_strobe_n_o)
        |-> $stable(card_addr_o) && $stable(card_write_enable_n_o); endproperty
    a_hold: assert property (p_hold) else $error("card lines moved");
    property p_release; !card_transfer_strobe_n_o && !card_ready_n_i |=> card_transfer_strobe_n_o; endproperty
    a_release: assert property (p_release) else $error("strobe kept after ready");
    property p_ack; !card_transfer_strobe_n_o && !card_ready_n_i |-> ##2 wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack after ready");
    property p_dir; $fell(card_transfer_strobe_n_o)
        |-> card_write_enable_n_o == !(wb_we_i && wb_sel_i[0]); endproperty
    a_dir: assert property (p_dir) else $error("wrong direction");
    property p_addr; $fell(card_transfer_strobe_n_o) |-> card_addr_o == wb_adr_i[5:0]; endproperty
    a_addr: assert property (p_addr) else $error("wrong card address");
    property p_wdata; !card_write_enable_n_o
        |-> !card_data_oe_n_o && card_data_o == wb_dat_i[7:0]; endproperty
    a_wdata: assert property (p_wdata) else $error("wrong write byte");
    property p_site; !$stable(site_reset_n_o) |-> rst_wr || |wr_hist_r; endproperty
    a_site: assert property (p_site) else $error("site reset moved alone");
    property p_ext; !$stable(extender_reset_n_o) |-> rst_wr || |wr_hist_r; endproperty
    a_ext: assert property (p_ext) else $error("extender reset moved alone");
    property p_tout; low_cnt_r <= TOUT_CYC; endproperty
    a_tout: assert property (p_tout) else $error("strobe too long");
endmodule

bind dcp_port dcp_port_sva #(.TOUT_CYC(TOUT_CYC)) i_dcp_port_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .io_space_i(io_space_i),
    .card_transfer_strobe_n_o(card_transfer_strobe_n_o),
    .card_write_enable_n_o(card_write_enable_n_o), .card_addr_o(card_addr_o),
    .card_data_o(card_data_o), .card_data_oe_n_o(card_data_oe_n_o),
    .card_ready_n_i(card_ready_n_i), .site_reset_n_o(site_reset_n_o),
    .extender_reset_n_o(extender_reset_n_o)
);

// ---- bench/dcp_card_model.sv ----
// behavioural daughter card on the far side of the port
module dcp_card_model (
    // clock
    input  wire logic       clk_i,
    // port side
    input  wire logic       strobe_n_i,
    input  wire logic       we_n_i,
    input  wire logic [5:0] addr_i,
    input  wire logic [7:0] data_i,
    // answer latency, ff never answers
    input  wire logic [7:0] lat_i,
    // card drivers
    output logic [7:0]      data_o,
    output logic            ready_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [64];
    logic [7:0] cnt_r;
    logic [7:0] last_r;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {cnt_r, last_r, data_o, ready_n_o} = {24'h00_0000, 1'b1};
    end
    always @(posedge clk_i) begin
        ready_n_o <= 1'b1;
        if (strobe_n_i) begin
            cnt_r <= 8'h00;
            data_o <= ~last_r;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            data_o <= mem[addr_i];
            last_r <= mem[addr_i];
            // card ends cycle, write enable stores
            if (cnt_r == lat_i && lat_i != 8'hff) begin
                ready_n_o <= 1'b0;
                if (!we_n_i) mem[addr_i] <= data_i;
            end
        end
    end
endmodule

// ---- bench/dcp_port_tb.sv ----
// testbench for the daughter card parallel port
module dcp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TOUT = 8;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, io_sp, wb_ack;
    logic        str_n, we_n, oe_n, rdy_n, site_n, ext_n;
    logic [7:0]  wb_adr, lat, c_dout, c_din;
    logic [5:0]  c_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rd;
    int          n_fail = 0, checks_done = 0, n_strb = 0, cyc_n, base;

    dcp_port #(.TOUT_CYC(TOUT)) i_dcp_port (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .io_space_i(io_sp), .card_transfer_strobe_n_o(str_n), .card_write_enable_n_o(we_n),
        .card_addr_o(c_adr), .card_data_o(c_dout), .card_data_oe_n_o(oe_n),
        .card_data_i(c_din), .card_ready_n_i(rdy_n), .site_reset_n_o(site_n),
        .extender_reset_n_o(ext_n));
    dcp_card_model i_dcp_card_model (.clk_i(clk_i), .strobe_n_i(str_n), .we_n_i(we_n),
        .addr_i(c_adr), .data_i(c_dout), .lat_i(lat), .data_o(c_din), .ready_n_o(rdy_n));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (str_n === 1'b0) n_strb++;

    function automatic logic [31:0] z(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // ==========================================================
    // one classic wishbone cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic i);
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel, io_sp} <= {2'h3, w, a, d, s, i};
        cyc_n = 0;
        do begin
            @(posedge clk_i);
            cyc_n++;
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        {wb_cyc, wb_stb} <= 2'h0;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        chk(z({2'h0, str_n, we_n, oe_n, site_n, ext_n, wb_ack}), z(8'h3e));
        wb(1'b0, dcp_pkg::DCP_CTRL_ADDR, 32'h0000_0000, 4'hf, 1'b0);
        chk(rd, z(8'h00));
        wb(1'b0, dcp_pkg::DCP_WAIT_ADDR, 32'h0000_0000, 4'hf, 1'b0);
        chk(rd, z({4'h0, dcp_pkg::DCP_WAIT_RST}));
        wb(1'b1, dcp_pkg::DCP_WAIT_ADDR, 32'hffff_fff2, 4'hf, 1'b0);
        wb(1'b0, dcp_pkg::DCP_WAIT_ADDR, 32'h0000_0000, 4'hf, 1'b0);
        chk(rd, z(8'h02));
        wb(1'b0, 8'h10, 32'h0000_0000, 4'hf, 1'b0);
        chk(rd, z(8'h00));
    endtask
    task automatic t_refused();
        base = n_strb;
        wb(1'b0, 8'h05, 32'h0000_0000, 4'h1, 1'b1);
        chk(rd, z(8'hff));
        chk(32'(n_strb - base), 32'h0000_0000);
    endtask
    task automatic t_rst();
        logic [1:0] k;
        for (int v = 0; v < 5; v++) begin
            k = 2'(v % 4);
            wb(1'b1, dcp_pkg::DCP_RESET_ADDR, {30'h2aaa_aaaa, k}, 4'h1, 1'b0);
            wb(1'b0, dcp_pkg::DCP_RESET_ADDR, 32'h0000_0000, 4'hf, 1'b0);
            chk(rd, z({6'h00, k}));
            chk(z({6'h00, site_n, ext_n}), z({6'h00, ~k[0], ~k[1]}));
        end
    endtask
    task automatic t_card();
        logic [5:0] ad [3] = '{6'h00, 6'h3f, 6'h15};
        logic [7:0] dt [3] = '{8'ha5, 8'h5a, 8'hff};
        logic [7:0] lt [3] = '{8'h00, 8'h03, 8'h01};
        wb(1'b1, dcp_pkg::DCP_CTRL_ADDR, 32'h0000_0001, 4'h1, 1'b0);
        for (int i = 0; i < 3; i++) begin
            lat <= lt[i];
            wb(1'b1, {2'h2, ad[i]}, {24'hde_adbe, dt[i]}, 4'hf, 1'b1);
            if (i == 0) base = cyc_n;
            if (i == 1) chk(32'(cyc_n - base), 32'h0000_0003);
            wb(1'b0, {2'h2, ad[i]}, 32'h0000_0000, 4'hf, 1'b1);
            chk(rd, z(dt[i]));
        end
        wb(1'b1, 8'h00, 32'h0000_0011, 4'he, 1'b1);
        wb(1'b0, 8'h00, 32'h0000_0000, 4'hf, 1'b1);
        chk(rd, z(8'ha5));
    endtask
    task automatic t_tout();
        lat <= 8'hff;
        wb(1'b0, 8'h07, 32'h0000_0000, 4'h1, 1'b1);
        chk(rd, z(8'hff));
        chk(32'(cyc_n > TOUT), 32'h0000_0001);
        lat <= 8'h00;
        wb(1'b0, dcp_pkg::DCP_STATUS_ADDR, 32'h0000_0000, 4'hf, 1'b0);
        chk(rd, z(8'h06));
        wb(1'b1, dcp_pkg::DCP_STATUS_ADDR, 32'h0000_0004, 4'h1, 1'b0);
        wb(1'b0, dcp_pkg::DCP_STATUS_ADDR, 32'h0000_0000, 4'hf, 1'b0);
        chk(rd, z(8'h02));
    endtask
    task automatic t_reset();
        wb(1'b1, dcp_pkg::DCP_RESET_ADDR, 32'h0000_0003, 4'h1, 1'b0);
        @(posedge clk_i);
        chk(z({6'h00, site_n, ext_n}), z(8'h00));
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(z({6'h00, site_n, ext_n}), z(8'h03));
        wb(1'b0, dcp_pkg::DCP_WAIT_ADDR, 32'h0000_0000, 4'hf, 1'b0);
        chk(rd, z({4'h0, dcp_pkg::DCP_WAIT_RST}));
        base = n_strb;
        wb(1'b0, 8'h05, 32'h0000_0000, 4'h1, 1'b1);
        chk(rd, z(8'hff));
        chk(32'(n_strb - base), 32'h0000_0000);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel, io_sp} = '0;
        lat = 8'h00;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_refused();
        t_rst();
        t_card();
        t_tout();
        t_reset();
        conclude();
    end
    initial begin
        #200_000;
        n_fail++;
        conclude();
    end
endmodule
